/* File: verilog/bmsc_burst_ctrl.sv */
// Contract
// [R1] min power and above threshold: enter burst-off
// [R2] burst-off, below threshold: start new burst
// [R3] pulses per burst follow output power demand
// [R4] pulse count never below one
// [R5] single-pulse bursts: repetition rate keeps falling
// [R6] non-switching burst phase: low-consumption state
// [R7] below fast-start level: switch until it clears
// [R8] above fast-stop level: stop switching at once
// [R9] fast overrides affect present burst only
// [R10] reduce pulses only if rate stays below target
// [R11] regulate toward target repetition period
// [R12] on-time over 1.5 target periods: normal mode
// [R13] soft start ramps limit in fifteen steps
// [R14] soft-start timing from internal 3.7 ms constant
// [R15] comparator inputs pass two-flop synchronisers
//
// Purpose: burst sequencing, pulse count regulation and soft start
// Assumes: comparator and run levels are asynchronous to clock_i
// Notes: min_power_i comes from logic on the same clock
`include "bmsc_params.svh"

module bmsc_burst_ctrl
  import bmsc_pkg::*;
#(
  parameter int SS_STEP_CYCLES =
    (`BMSC_SS_TC_NS * `BMSC_CLK_MHZ / 1000) / `BMSC_SS_STEPS,
  parameter int BURST_PERIOD_CYCLES =
    `BMSC_BURST_PERIOD_US * `BMSC_CLK_MHZ,
  parameter int SW_PERIOD_CYCLES =
    (`BMSC_CLK_MHZ * 1000000) / `BMSC_FSW_MIN_HZ,
  parameter int GATE_ON_CYCLES =
    (`BMSC_GATE_ON_NS * `BMSC_CLK_MHZ + 999) / 1000,
  parameter int CNT_W = 20,
  parameter int NP_W = 6
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // power control state
  input wire logic min_power_i,
  input wire logic run_i,
  // feedback current comparators
  input wire logic burst_thr_i,
  input wire logic fast_start_i,
  input wire logic fast_stop_i,
  // gate and status
  output logic gate_req_o,
  output logic burst_mode_o,
  output logic low_power_o,
  output logic [3:0] peak_step_o,
  output logic ss_done_o
);
  localparam int ON_LIMIT_CYCLES = BURST_PERIOD_CYCLES *
    `BMSC_ON_LIMIT_NUM / `BMSC_ON_LIMIT_DEN;
  localparam logic [3:0] SS_LAST = 4'(`BMSC_SS_STEPS);
  localparam logic [NP_W-1:0] NP_MIN = NP_W'(`BMSC_PULSES_MIN);
  localparam logic [NP_W-1:0] NP_MAX = '1;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  typedef struct packed {
    bmsc_state_t st;
    logic [CNT_W-1:0] per;
    logic [CNT_W-1:0] on_t;
    logic [15:0] cyc;
    logic [NP_W-1:0] pcnt;
    logic [NP_W-1:0] npul;
    logic ovr;
    logic per_ok;
    logic run_d;
    logic [3:0] step;
    logic [15:0] ss_cnt;
    logic gate;
    logic burst;
    logic lowp;
    logic ssd;
  } bmsc_regs_t;

  bmsc_regs_t s;
  bmsc_regs_t next_s;
  logic [3:0] cmp;
  logic run;
  logic thr;
  logic fstart;
  logic fstop;

  // analog comparators and the run level are not on our clock
  bmsc_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({run_i, burst_thr_i, fast_start_i, fast_stop_i}),
    .sync_o(cmp)
  ); // R15

  assign run = cmp[3];
  assign thr = cmp[2];
  assign fstart = cmp[1];
  assign fstop = cmp[0];

  // one pass computes the whole next state
  always_comb begin
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = '0;
    rhs = '0;
    next_s = s;
    next_s.run_d = run;
    // switching-cycle timer; wraps each period and restarts at each burst start
    if (s.cyc >= 16'(SW_PERIOD_CYCLES - 1)) begin
      next_s.cyc = '0;
    end else begin
      next_s.cyc = s.cyc + 16'h0001;
    end
    if (!run) begin
      // stopped: back to normal mode, soft start and override cleared, pulse count kept; the next run restarts soft start
      next_s.st = BMSC_NORMAL;
      next_s.step = '0;
      next_s.ss_cnt = '0;
      next_s.ovr = 1'b0;
      next_s.per_ok = 1'b0;
    end else begin
      // soft-start ramp of the peak-current limit
      if (!s.run_d) begin
        next_s.step = 4'h1; // R13
        next_s.ss_cnt = '0;
      end else if (s.step < SS_LAST) begin
        if (s.ss_cnt >= 16'(SS_STEP_CYCLES - 1)) begin
          next_s.ss_cnt = '0;
          next_s.step = s.step + 4'h1; // R13 R14
        end else begin
          next_s.ss_cnt = s.ss_cnt + 16'h0001; // R14
        end
      end
      // burst sequencer
      case (s.st)
        BMSC_NORMAL: begin
          if (fstop || (min_power_i && thr)) begin
            next_s.st = BMSC_OFF; // R1 R8
            next_s.per = '0;
            next_s.per_ok = 1'b0;
          end
        end
        BMSC_OFF: begin
          if (s.per != CNT_MAX) begin
            next_s.per = s.per + CNT_W'(1);
          end
          if (!fstop && (fstart || !thr)) begin
            next_s.st = BMSC_ON; // R2 R7
            next_s.cyc = '0;
            next_s.pcnt = NP_W'(1);
            next_s.on_t = '0;
            next_s.per = '0;
            next_s.per_ok = 1'b1;
            // a fresh burst starts clean of any past override
            next_s.ovr = fstart; // R9
            if (s.per_ok && !s.ovr) begin
              lhs = 32'(s.per) * 32'(s.npul - NP_W'(1));
              rhs = 32'(BURST_PERIOD_CYCLES) * 32'(s.npul);
              if (32'(s.per) < 32'(BURST_PERIOD_CYCLES)) begin
                // rate above target: more pulses per burst
                if (s.npul != NP_MAX) begin
                  next_s.npul = s.npul + NP_W'(1); // R3 R11
                end
              end else if (s.npul > NP_MIN && lhs >= rhs) begin
                next_s.npul = s.npul - NP_W'(1); // R3 R4 R10
              end
              // at one pulse the off time simply stretches
            end // R5
          end
        end
        BMSC_ON: begin
          if (s.per != CNT_MAX) begin
            next_s.per = s.per + CNT_W'(1);
          end
          if (s.on_t != CNT_MAX) begin
            next_s.on_t = s.on_t + CNT_W'(1);
          end
          if (fstart) begin
            next_s.ovr = 1'b1; // R9
          end
          if (fstop) begin
            next_s.st = BMSC_OFF; // R8
            next_s.ovr = 1'b1; // R9
          end else if (32'(s.on_t) >= 32'(ON_LIMIT_CYCLES)) begin
            next_s.st = BMSC_NORMAL; // R12
          end else if (s.cyc >= 16'(SW_PERIOD_CYCLES - 1)) begin
            // burst ends after its last pulse unless held on
            if (s.pcnt >= s.npul && !fstart) begin
              next_s.st = BMSC_OFF; // R3 R7
            end else if (s.pcnt != NP_MAX) begin
              next_s.pcnt = s.pcnt + NP_W'(1);
            end
          end
        end
        default: begin
          next_s.st = BMSC_NORMAL;
        end
      endcase
    end
    // outputs are registered from the next state
    next_s.gate = run && (next_s.st != BMSC_OFF) &&
                  (next_s.cyc < 16'(GATE_ON_CYCLES)); // R8
    next_s.burst = run && (next_s.st != BMSC_NORMAL);
    next_s.lowp = run && (next_s.st == BMSC_OFF); // R6
    // registered so the status pin cannot glitch on a step compare
    next_s.ssd = (next_s.step == SS_LAST); // R13
  end

  // state register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '{st: BMSC_NORMAL, npul: NP_W'(`BMSC_PULSES_INIT),
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign gate_req_o = s.gate;
  assign burst_mode_o = s.burst;
  assign low_power_o = s.lowp;
  assign peak_step_o = s.step;
  assign ss_done_o = s.ssd;

  // checks on the sequencing
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence run_rise_s;
    run && !s.run_d;
  endsequence

  sequence first_step_s;
    s.step == 4'h1;
  endsequence

  entry_burst_a: assert property ( // R1
    (run && s.st == BMSC_NORMAL && min_power_i && thr)
      |=> (s.st == BMSC_OFF && burst_mode_o && !gate_req_o))
    else $error("burst entry missed");

  new_burst_a: assert property ( // R2
    (run && s.st == BMSC_OFF && !thr && !fstop)
      |=> (s.st == BMSC_ON && gate_req_o))
    else $error("new burst did not start");

  pulse_floor_a: assert property ( // R4
    s.npul >= NP_MIN)
    else $error("pulse count below floor");

  low_power_a: assert property ( // R6
    (s.st == BMSC_OFF && run) |-> (low_power_o && !gate_req_o))
    else $error("low power state not held");

  fast_start_a: assert property ( // R7
    (run && !fstop && fstart && s.st != BMSC_NORMAL &&
     !(s.st == BMSC_ON && 32'(s.on_t) >= 32'(ON_LIMIT_CYCLES)))
      |=> (s.st == BMSC_ON))
    else $error("fast start did not switch");

  fast_stop_a: assert property ( // R8
    fstop |=> (!gate_req_o && s.st != BMSC_ON))
    else $error("fast stop did not halt");

  on_limit_a: assert property ( // R12
    (run && !fstop && s.st == BMSC_ON &&
     32'(s.on_t) >= 32'(ON_LIMIT_CYCLES))
      |=> (s.st == BMSC_NORMAL && !burst_mode_o))
    else $error("long burst kept burst mode");

  ss_start_a: assert property ( // R13
    run_rise_s |=> first_step_s ##1 (s.step == 4'h1))
    else $error("soft start did not begin at step one");

  ss_bound_a: assert property ( // R13
    (s.step <= SS_LAST) && (s.step == $past(s.step) ||
     s.step == $past(s.step) + 4'h1 || s.step <= 4'h1))
    else $error("soft start step jumped");

  reduce_a: assert property ( // R10
    (run && s.st == BMSC_OFF && s.per_ok && !s.ovr && !fstop &&
     !thr && 32'(s.per) * 32'(s.npul - NP_W'(1)) <
     32'(BURST_PERIOD_CYCLES) * 32'(s.npul))
      |=> (s.npul >= $past(s.npul)))
    else $error("pulse count cut above target rate");

  // the last pulse period closes the burst unless an override holds it
  burst_end_a: assert property ( // R3
    (run && s.st == BMSC_ON && !fstop && !fstart && s.pcnt >= s.npul &&
     32'(s.on_t) < 32'(ON_LIMIT_CYCLES) &&
     s.cyc >= 16'(SW_PERIOD_CYCLES - 1))
      |=> (s.st == BMSC_OFF && !gate_req_o))
    else $error("burst ran past its pulse count");

  // an overridden burst leaves the pulse count alone for one update
  override_once_a: assert property ( // R9
    (run && s.st == BMSC_OFF && s.ovr && !fstop && (fstart || !thr))
      |=> (s.npul == $past(s.npul)))
    else $error("pulse count moved after an override");

  // after the first running cycle, the limit only moves at the end of a full step interval
  step_hold_a: assert property ( // R14
    (run && s.run_d && s.ss_cnt < 16'(SS_STEP_CYCLES - 1))
      |=> (s.step == $past(s.step)))
    else $error("soft start step came early");
endmodule

/* File: verilog/bmsc_params.svh */
// Purpose: constants of the burst-mode switch control block
// Assumes: 100 MHz core clock
// Notes: times are kept in their own unit, counts derive from them
`ifndef BMSC_PARAMS_SVH
`define BMSC_PARAMS_SVH

// core clock rate
`define BMSC_CLK_MHZ 100
// soft-start time constant and number of limit steps
`define BMSC_SS_TC_NS 3700000
`define BMSC_SS_STEPS 15
// lowest_switching_frequency of the gate pulse train
`define BMSC_FSW_MIN_HZ 25000
// gate on-time of each pulse request
`define BMSC_GATE_ON_NS 1000
// target burst repetition period
`define BMSC_BURST_PERIOD_US 1000
// burst on-time limit is NUM/DEN times the target period
`define BMSC_ON_LIMIT_NUM 3
`define BMSC_ON_LIMIT_DEN 2
// pulse count floor and value after reset
`define BMSC_PULSES_MIN 1
`define BMSC_PULSES_INIT 4

`endif

/* File: verilog/bmsc_pkg.sv */
// Purpose: types of the burst-mode switch control block
// Assumes: nothing beyond the parameter header
// Notes: state codes are gray along normal -> off -> on
package bmsc_pkg;
  typedef enum logic [1:0] {
    BMSC_NORMAL = 2'h0,
    BMSC_OFF = 2'h1,
    BMSC_ON = 2'h3
  } bmsc_state_t;
endpackage

/* File: verilog/bmsc_sync.sv */
// Purpose: two-flop synchroniser for a group of asynchronous levels
// Assumes: each bit is an independent level
// Notes: only the second stage may be read by logic
module bmsc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  // the first stage feeds only the second one
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

/* File: tb/bmsc_fb_model.sv */
// Purpose: feedback comparators and gate pulse counter at the far side
// Assumes: levels are commanded by the bench
// Notes: comparator edges land off the clock edge, as real async levels
module bmsc_fb_model (
  // clock
  input wire logic clock_i,
  // commanded feedback levels
  input wire logic thr_i,
  input wire logic fstart_i,
  input wire logic fstop_i,
  // gate observation
  input wire logic gate_i,
  input wire logic clr_i,
  // comparator outputs and pulse count
  output logic burst_thr_o,
  output logic fast_start_o,
  output logic fast_stop_o,
  output logic [7:0] pulses_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev;
  // analog delay keeps comparator edges away from the sampling edge
  assign #3 burst_thr_o = thr_i;
  assign #3 fast_start_o = fstart_i;
  assign #3 fast_stop_o = fstop_i;
  // count rising edges of the gate request
  always @(posedge clock_i) begin
    prev <= gate_i;
    if (clr_i) pulses_o <= 8'h00;
    else if (gate_i && !prev) pulses_o <= pulses_o + 8'h01;
  end
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench of the burst sequencer and soft start
// Assumes: shortened counts through parameters
// Notes: inputs move 1 ns after the rising edge
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SS = 20;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic min_power_i = 1'b0;
  logic run_i = 1'b0;
  logic thr = 1'b0, fstart = 1'b0, fstop = 1'b0, clr = 1'b0;
  logic burst_thr, fast_start, fast_stop;
  logic gate_req_o, burst_mode_o, low_power_o, ss_done_o;
  logic [3:0] peak_step_o;
  logic [7:0] pulses;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  // free-running core clock
  always #5 clock_i = ~clock_i;
  bmsc_burst_ctrl #(.SS_STEP_CYCLES(SS), .BURST_PERIOD_CYCLES(2000),
    .SW_PERIOD_CYCLES(10), .GATE_ON_CYCLES(3)) u_bmsc_burst_ctrl (
    .clock_i(clock_i), .rst_i(rst_i), .min_power_i(min_power_i),
    .run_i(run_i), .burst_thr_i(burst_thr), .fast_start_i(fast_start),
    .fast_stop_i(fast_stop), .gate_req_o(gate_req_o),
    .burst_mode_o(burst_mode_o), .low_power_o(low_power_o),
    .peak_step_o(peak_step_o), .ss_done_o(ss_done_o));
  bmsc_fb_model u_bmsc_fb_model (.clock_i(clock_i), .thr_i(thr),
    .fstart_i(fstart), .fstop_i(fstop), .gate_i(gate_req_o), .clr_i(clr),
    .burst_thr_o(burst_thr), .fast_start_o(fast_start),
    .fast_stop_o(fast_stop), .pulses_o(pulses));
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang ends the run as a mismatch
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic t_soft_start();
    run_i = 1'b1;
    tick(3);
    check(peak_step_o, 8'h01);
    n = 0;
    // gates run from step one; their phase follows the switching timer
    while (gate_req_o !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    check(gate_req_o, 1'b1);
    while (ss_done_o !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    // fourteen further steps of SS cycles each
    check(n >= 14 * SS - 3 && n <= 14 * SS + 3, 1'b1);
    check(peak_step_o, 8'h0F);
    check(ss_done_o, 1'b1);
    $display("soft start done");
  endtask
  task automatic t_entry();
    min_power_i = 1'b1;
    thr = 1'b1;
    tick(6);
    check({burst_mode_o, low_power_o, gate_req_o}, 8'h06);
    $display("burst entry done");
  endtask
  // idle for off cycles, then one burst; its pulses are counted
  task automatic t_burst(input int off, input logic [7:0] exp);
    tick(off);
    clr = 1'b1;
    thr = 1'b0;
    tick(1);
    clr = 1'b0;
    for (int i = 0; i < 20 && low_power_o !== 1'b0; i++) tick(1);
    thr = 1'b1;
    for (int i = 0; i < 300 && low_power_o !== 1'b1; i++) tick(1);
    check(pulses, exp);
    check(burst_mode_o, 1'b1);
    check(low_power_o, 1'b1);
    $display("burst of %0d pulses done", exp);
  endtask
  task automatic t_fast_stop();
    thr = 1'b0;
    for (int i = 0; i < 20 && low_power_o !== 1'b0; i++) tick(1);
    tick(4);
    fstop = 1'b1;
    thr = 1'b1;
    tick(4);
    check({low_power_o, gate_req_o}, 8'h02);
    fstop = 1'b0;
    $display("fast stop done");
  endtask
  task automatic t_fast_start();
    // demand rises above minimum, so leaving burst mode is not re-entered
    min_power_i = 1'b0;
    fstart = 1'b1;
    clr = 1'b1;
    tick(5);
    clr = 1'b0;
    check(low_power_o, 1'b0);
    tick(200);
    check(pulses > 8'h08, 1'b1);
    tick(3000);
    check(burst_mode_o, 1'b0);
    fstart = 1'b0;
    $display("fast start done");
  endtask
  initial begin
    tick(20);
    check({burst_mode_o, low_power_o, gate_req_o, peak_step_o}, 8'h00);
    rst_i = 1'b0;
    tick(2);
    t_soft_start();
    t_entry();
    t_burst(50, 8'h04);
    t_burst(100, 8'h05);
    t_burst(3000, 8'h04);
    tick(100);
    t_fast_stop();
    t_burst(100, 8'h05);
    t_fast_start();
    test_done();
  end
endmodule
